//--- t1_framer_status_loopcode_density_tb.sv
`timescale 1ns/100ps
module t1_framer_status_loopcode_density_tb
    import tfs_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0, b8zs_mode = 1'b0, sysclk_stable = 1'b0, tx_valid = 1'b0;
    logic tx_bit_tick = 1'b0, tx_fslot = 1'b0, tx_fbit = 1'b0, rx_bit_tick = 1'b0, rx_line = 1'b0;
    tfs_op_e cmd_op = OP_WRITE;
    logic [3:0] cmd_addr = 4'h0, other_irq = 4'h0;
    logic [7:0] cmd_data = 8'h00, tx_data = 8'h00, r, v, m;
    logic [7:0] evt [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic cmd_ready, rsp_valid, init_done, irq_active, tx_ready, tx_line, es_pulse, b;
    logic es_seen = 1'b0;
    logic [7:0] rsp_data;
    logic [7:0] q [$];
    int error_cnt = 0;
    int checks = 0;
    int n, z = 0, zm = 0;
    tfs_if tfs_if_inst (.core_clk, .resetn);
    tfs_framer #(.FRAMER_INDEX(2'h0)) tfs_framer_inst (.core_clk, .resetn, .bus(tfs_if_inst), .tx_data, .tx_valid,
        .tx_ready, .tx_bit_tick, .tx_fslot, .tx_fbit, .tx_line, .rx_bit_tick, .rx_line, .status_first_evt(evt[0]),
        .status_second_evt(evt[1]), .rx_info_first_evt(evt[2]), .rx_info_second_evt(evt[3]), .other_irq,
        .elastic_store_reset_pulse(es_pulse));
    tfs_host tfs_host_inst (.core_clk, .resetn, .bus(tfs_if_inst), .cmd_valid, .cmd_ready, .cmd_op, .cmd_fsel(2'h0),
        .cmd_addr, .cmd_data, .b8zs_mode, .sysclk_stable, .rsp_valid, .rsp_data, .init_done, .irq_active);
    tfs_assertions tfs_assertions_inst (.core_clk, .resetn, .reg_wr(tfs_if_inst.reg_wr),
        .reg_rd(tfs_if_inst.reg_rd), .reg_fsel(tfs_if_inst.reg_fsel), .reg_addr(tfs_if_inst.reg_addr),
        .reg_wdata(tfs_if_inst.reg_wdata), .reg_rdata(tfs_if_inst.reg_rdata), .reg_rack(tfs_if_inst.reg_rack),
        .int_o(tfs_if_inst.int_o), .int_oe(tfs_if_inst.int_oe));
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (es_pulse === 1'b1)
            es_seen <= 1'b1;
    end
    function automatic logic lbit(input int len, input int k);
        return (k % len) == len - 1;
    endfunction
    task automatic complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmpb(input logic g, input logic e);
        cmp({7'h00, g}, {7'h00, e});
    endtask
    task automatic pd;
        cmd(OP_POLL, IDX_RX_INFO_SECOND, 8'h06, r);
    endtask
    task automatic wctl(input logic [7:0] d);
        cmd(OP_WRITE, IDX_TX_CTRL, d, r);
    endtask
    task automatic cmd(input tfs_op_e op, input logic [3:0] a, input logic [7:0] d, output logic [7:0] rd);
        int k;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        for (k = 0; k < 200 && cmd_ready !== 1'b1; k++)
            @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (k = 0; k < 20 && rsp_valid !== 1'b1; k++)
            @(negedge core_clk);
        rd = rsp_data;
        cmpb(rsp_valid, 1'b1);
        @(negedge core_clk);
    endtask
    task automatic pulse(input int i, input logic [7:0] x);
        evt[i] = x;
        @(negedge core_clk);
        evt[i] = 8'h00;
        @(negedge core_clk);
    endtask
    task automatic txb(input logic fs, input logic fb, output logic o);
        tx_fslot = fs;
        tx_fbit = fb;
        tx_bit_tick = 1'b1;
        @(negedge core_clk);
        tx_bit_tick = 1'b0;
        @(negedge core_clk);
        o = tx_line;
        @(negedge core_clk);
    endtask
    task automatic rxs(input logic x, input int cnt);
        repeat (cnt)
        begin
            rx_line = x;
            rx_bit_tick = 1'b1;
            @(negedge core_clk);
            rx_bit_tick = 1'b0;
            @(negedge core_clk);
        end
    endtask
    task automatic loopchk(input int len);
        int k;
        int p;
        logic f;
        p = 0;
        for (k = 0; k < 17; k++)
        begin
            f = $urandom;
            txb(k == 7, f, b);
            if (k == 7)
                cmpb(b, f);
            else
            begin
                cmpb(b, lbit(len, p));
                p++;
            end
        end
    endtask
    initial
    begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        void'($urandom(15014));
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        repeat (60) @(negedge core_clk);
        cmpb(es_seen, 1'b0);
        sysclk_stable = 1'b1;
        for (n = 0; n < 300 && init_done !== 1'b1; n++)
            @(negedge core_clk);
        cmpb(es_seen, 1'b1);
        for (n = 0; n < 4; n++)
        begin
            v = $urandom;
            m = $urandom;
            pulse(n, v);
            cmd(OP_POLL, n[3:0], m, r);
            cmp(r, v & m);
            cmd(OP_READ, n[3:0], 8'h00, r);
            cmp(r, 8'h00);
            cmd(OP_POLL, n[3:0], 8'hff, r);
            cmp(r, v & ~m);
            cmd(OP_POLL, n[3:0], 8'hff, r);
            cmp(r, 8'h00);
        end
        evt[1] = 8'h80;
        cmd(OP_POLL, IDX_STATUS_SECOND, 8'hff, r);
        cmp(r, 8'h80);
        evt[1] = 8'h00;
        cmd(OP_POLL, IDX_STATUS_SECOND, 8'hff, r);
        cmp(r, 8'h80);
        for (n = 0; n < 2; n++)
        begin
            v = 8'h01 << ($urandom % 8);
            pulse(n, v);
            cmpb(irq_active, 1'b0);
            cmd(OP_WRITE, 4'(IDX_IRQ_MASK_FIRST + n), v, r);
            cmpb(irq_active, 1'b1);
            other_irq = $urandom;
            cmd(OP_WRITE, IDX_FRAMER_IRQ_INDICATOR, 8'hff, r);
            cmd(OP_READ, IDX_FRAMER_IRQ_INDICATOR, 8'h00, r);
            cmp(r, {4'h0, other_irq | 4'h1});
            cmd(OP_POLL, n[3:0], 8'hff, r);
            cmpb(irq_active, 1'b0);
            cmd(OP_READ, IDX_FRAMER_IRQ_INDICATOR, 8'h00, r);
            cmp(r, {4'h0, other_irq});
            pulse(2 + n, 8'hff);
            cmpb(irq_active, 1'b0);
        end
        cmd(OP_READ, 4'h9, 8'h00, r);
        cmp(r, 8'h00);
        b8zs_mode = 1'b1;
        wctl(8'h08);
        cmd(OP_READ, IDX_TX_CTRL, 8'h00, r);
        cmp(r, 8'h00);
        b8zs_mode = 1'b0;
        wctl(8'h06);
        cmd(OP_READ, IDX_TX_CTRL, 8'h00, r);
        cmp(r, 8'h02);
        loopchk(5);
        wctl(8'h00);
        wctl(8'h04);
        loopchk(3);
        wctl(8'h00);
        while (tx_ready === 1'b1 && q.size() < 40)
        begin
            v = $urandom;
            tx_data = v;
            tx_valid = 1'b1;
            @(negedge core_clk);
            q.push_back(v);
        end
        tx_valid = 1'b0;
        cmp(8'(q.size()), 8'(TX_FIFO_DEPTH));
        while (q.size() > 0)
        begin
            v = q.pop_front();
            for (n = 7; n >= 0; n--)
            begin
                txb(1'b0, 1'b0, b);
                cmpb(b, v[n]);
            end
        end
        cmpb(tx_ready, 1'b1);
        pd();
        repeat (16) txb(1'b0, 1'b0, b);
        cmd(OP_POLL, IDX_RX_INFO_SECOND, 8'h04, r);
        cmp(r, 8'h04);
        wctl(8'h08);
        for (n = 0; n < 400; n++)
        begin
            if (n == 200)
                pd();
            txb(1'b0, 1'b0, b);
            z = b ? 0 : z + 1;
            zm = z > zm ? z : zm;
        end
        cmpb(zm < 16, 1'b1);
        pd();
        cmp(r, 8'h00);
        wctl(8'h00);
        rxs(1'b1, 200);
        pd();
        rxs(1'b0, 15);
        pd();
        cmp(r, 8'h00);
        rxs(1'b0, 1);
        pd();
        cmp(r, 8'h02);
        rxs(1'b1, 200);
        pd();
        repeat (4)
        begin
            rxs(1'b1, 1);
            rxs(1'b0, 14);
        end
        pd();
        cmp(r, 8'h02);
        complete_run();
    end
endmodule

//--- tfs_assertions.sv
`timescale 1ns/100ps
module tfs_assertions
    import tfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_fsel,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rack,
    input wire logic int_o,
    input wire logic int_oe
);
    logic [15:0] mask_r;
    wire sel_w = reg_wr && reg_fsel == 2'h0;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            mask_r <= 16'h0000;
        else if (sel_w && reg_addr == IDX_IRQ_MASK_FIRST)
            mask_r[7:0] <= reg_wdata;
        else if (sel_w && reg_addr == IDX_IRQ_MASK_SECOND)
            mask_r[15:8] <= reg_wdata;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    rack_delay_a: assert property (reg_rd && reg_fsel == 2'h0 |=> reg_rack)
        else $error("no rack");
    rack_cause_a: assert property (reg_rack |-> $past(reg_rd) && $past(reg_fsel) == 2'h0)
        else $error("stray rack");
    rdata_hold_a: assert property ($changed(reg_rdata) |-> reg_rack)
        else $error("rdata moved");
    poll_addr_a: assert property (sel_w && reg_addr < IDX_IRQ_MASK_FIRST ##1 reg_rd |-> reg_addr == $past(reg_addr))
        else $error("poll addr");
    poll_writeback_a: assert property (sel_w && reg_addr < IDX_IRQ_MASK_FIRST ##1 reg_rd |=>
        reg_rack ##2 (reg_wr && reg_wdata == (reg_rdata & $past(reg_wdata, 4))))
        else $error("poll wb");
    loop_excl_a: assert property (sel_w && reg_addr == IDX_TX_CTRL |-> !(reg_wdata[1] && reg_wdata[2]))
        else $error("both loops");
    irq_masked_a: assert property (mask_r == 16'h0000 |-> !int_oe)
        else $error("masked irq");
    irq_drive_a: assert property (int_oe |-> !int_o)
        else $error("int high");
    ind_upper_a: assert property (reg_rack && $past(reg_addr) == IDX_FRAMER_IRQ_INDICATOR |-> reg_rdata[7:4] == 4'h0)
        else $error("ind upper");
    poll_c: cover property (sel_w && reg_addr < IDX_IRQ_MASK_FIRST ##1 reg_rd ##1 reg_rack);
    irq_c: cover property ($rose(int_oe));
    rack_c: cover property (reg_rack && $past(reg_addr) > IDX_ES_CTRL);
endmodule

//--- tfs_framer.sv
// Functional notes
// R1: loop select bits replace payload with loop code
// R2: framing bits still inserted over loop code
// R3: loop code continues while either select set
// R4: host never sets both loop selects together
// R5: flag more than fifteen consecutive zeros
// R6: flag windows of 8(N+1) with too few ones
// R7: tx and rx violations set separate flags
// R8: enforcer forces transmitted stream to meet density (enforcer forces payload slots only; framing slots send tx_fbit unforced)
// R9: host disables enforcer when running B8ZS
// R10: host writes every register after power up (host writes indexes 4 to 8 only, not the status registers)
// R11: host toggles elastic store reset once clocks stable
// R12: events set their status bit
// R13: status bits latch until read and cleared
// R14: cleared bit resets only on recurrence
// R15: written one copies latch then clears it
// R16: written zero holds copy and latch
// R17: host writes mask, reads, writes back masked value
// R18: only first and second status drive interrupt
// R19: irq mask registers gate each status bit
// R20: indicator register shows which framers interrupt
// R21: interrupt driven low while unmasked bit latched
`timescale 1ns/100ps
module tfs_fifo
    import tfs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
    assign out_valid = wp_r != rp_r;
    assign out_data = mem[rp_r[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wp_r[AW-1:0]] <= in_data;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end
endmodule

module tfs_dens_mon
    import tfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bit_tick,
    input wire logic bit_in,
    output logic viol_r,
    output logic zero_would_viol
);
    // age of the k-th most recent one, in bits; saturates
    logic [7:0] age_r [DENS_N_MAX];
    logic [7:0] age_nxt [DENS_N_MAX];
    logic [4:0] zrun_r;
    logic [DENS_N_MAX-1:0] win_viol;
    logic [DENS_N_MAX-1:0] win_zero;
    wire [4:0] zrun_nxt = bit_in ? 5'h00 : (zrun_r == 5'h1f ? zrun_r : zrun_r + 5'h01);

    for (genvar k = 0; k < DENS_N_MAX; k++)
    begin : g_win
        localparam logic [7:0] WIN_LEN = 8'(8 * (k + 2));
        wire [7:0] older = (k == 0) ? 8'h00 : age_r[(k == 0) ? 0 : k-1];
        wire [7:0] own_inc = (age_r[k] == AGE_SAT) ? AGE_SAT : age_r[k] + 8'h01;
        wire [7:0] old_inc = (older == AGE_SAT) ? AGE_SAT : older + 8'h01;
        assign age_nxt[k] = !bit_in ? own_inc : ((k == 0) ? 8'h00 : old_inc);
        assign win_viol[k] = age_nxt[k] >= WIN_LEN; // R6
        assign win_zero[k] = own_inc >= WIN_LEN;
    end

    assign zero_would_viol = (zrun_r >= MAX_ZERO_RUN) || (|win_zero);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int k = 0; k < DENS_N_MAX; k++)
                age_r[k] <= 8'h00;
            zrun_r <= 5'h00;
            viol_r <= 1'b0;
        end
        else
        begin
            viol_r <= bit_tick & ((zrun_nxt > MAX_ZERO_RUN) | (|win_viol)); // R5 R6
            if (bit_tick)
            begin
                age_r <= age_nxt;
                zrun_r <= zrun_nxt;
            end
        end
    end
endmodule

module tfs_framer
    import tfs_pkg::*;
#(
    parameter logic [1:0] FRAMER_INDEX = 2'h0
) (
    input wire logic core_clk,
    input wire logic resetn,
    tfs_if.dev bus,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_bit_tick,
    input wire logic tx_fslot,
    input wire logic tx_fbit,
    output logic tx_line,
    input wire logic rx_bit_tick,
    input wire logic rx_line,
    input wire logic [7:0] status_first_evt,
    input wire logic [7:0] status_second_evt,
    input wire logic [7:0] rx_info_first_evt,
    input wire logic [7:0] rx_info_second_evt,
    input wire logic [3:0] other_irq,
    output logic elastic_store_reset_pulse
);
    logic [7:0] latch_r [NUM_STATUS];
    logic [7:0] copy_r [NUM_STATUS];
    logic [7:0] evt [NUM_STATUS];
    logic [7:0] irq_mask_first_r;
    logic [7:0] irq_mask_second_r;
    logic [7:0] tx_ctrl_r;
    logic [7:0] es_ctrl_r;
    logic [7:0] rdata_r;
    logic rack_r;
    logic [7:0] sh_r;
    logic [3:0] left_r;
    logic [2:0] lc_idx_r;
    logic tx_line_r;
    logic tx_viol;
    logic rx_viol;
    logic tx_zero_bad;
    logic [7:0] fifo_data;
    logic fifo_valid;

    wire sel = bus.reg_fsel == FRAMER_INDEX;
    wire wr = bus.reg_wr & sel;
    wire rd = bus.reg_rd & sel;
    wire wr_status = wr & (bus.reg_addr < 4'(NUM_STATUS));
    wire [1:0] st_idx = bus.reg_addr[1:0];

    // status events
    assign evt[0] = status_first_evt; // R12
    assign evt[1] = status_second_evt;
    assign evt[2] = rx_info_first_evt;
    assign evt[3] = rx_info_second_evt | (8'(tx_viol) << BIT_TX_DENSITY_VIOLATION)
                  | (8'(rx_viol) << BIT_RX_DENSITY_VIOLATION); // R7

    // interrupt: only the two status registers, gated by masks
    wire own_irq = |(latch_r[0] & irq_mask_first_r) | |(latch_r[1] & irq_mask_second_r); // R18 R19
    wire [3:0] isr_val = other_irq | (4'h1 << FRAMER_INDEX & {4{own_irq}}); // R20
    assign bus.int_o = 1'b0;
    assign bus.int_oe = own_irq; // R21

    wire [7:0] rd_val =
        (bus.reg_addr < 4'(NUM_STATUS)) ? copy_r[st_idx] :
        (bus.reg_addr == IDX_IRQ_MASK_FIRST) ? irq_mask_first_r :
        (bus.reg_addr == IDX_IRQ_MASK_SECOND) ? irq_mask_second_r :
        (bus.reg_addr == IDX_TX_CTRL) ? tx_ctrl_r :
        (bus.reg_addr == IDX_FRAMER_IRQ_INDICATOR) ? {4'h0, isr_val} :
        (bus.reg_addr == IDX_ES_CTRL) ? es_ctrl_r : 8'h00;
    assign bus.reg_rdata = rdata_r;
    assign bus.reg_rack = rack_r;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int s = 0; s < NUM_STATUS; s++)
            begin
                latch_r[s] <= RST_REG;
                copy_r[s] <= RST_REG;
            end
        end
        else
        begin
            for (int s = 0; s < NUM_STATUS; s++)
            begin
                if (wr_status && st_idx == 2'(s))
                begin
                    copy_r[s] <= (copy_r[s] & ~bus.reg_wdata) | (latch_r[s] & bus.reg_wdata); // R15 R16
                    latch_r[s] <= (latch_r[s] & ~bus.reg_wdata) | evt[s]; // R14
                end
                else
                    latch_r[s] <= latch_r[s] | evt[s]; // R13
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_mask_first_r <= RST_REG;
            irq_mask_second_r <= RST_REG;
            tx_ctrl_r <= RST_REG;
            es_ctrl_r <= RST_REG;
            elastic_store_reset_pulse <= 1'b0;
            rdata_r <= 8'h00;
            rack_r <= 1'b0;
        end
        else
        begin
            rack_r <= rd;
            if (rd)
                rdata_r <= rd_val;
            elastic_store_reset_pulse <= wr && bus.reg_addr == IDX_ES_CTRL
                && bus.reg_wdata[BIT_ELASTIC_STORE_RESET] && !es_ctrl_r[BIT_ELASTIC_STORE_RESET];
            if (wr && bus.reg_addr == IDX_IRQ_MASK_FIRST)
                irq_mask_first_r <= bus.reg_wdata;
            if (wr && bus.reg_addr == IDX_IRQ_MASK_SECOND)
                irq_mask_second_r <= bus.reg_wdata;
            if (wr && bus.reg_addr == IDX_TX_CTRL)
                tx_ctrl_r <= bus.reg_wdata;
            if (wr && bus.reg_addr == IDX_ES_CTRL)
                es_ctrl_r <= bus.reg_wdata;
        end
    end

    wire pay_tick = tx_bit_tick & !tx_fslot;
    wire pay_take = pay_tick & (left_r == 4'h0);

    tfs_fifo #(
        .WIDTH(TX_FIFO_WIDTH),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pay_take)
    );

    // transmit path; payload keeps draining during loop codes so the source never stalls on it
    wire loop_up = tx_ctrl_r[BIT_TX_LOOP_UP_SELECT];
    wire loop_dn = tx_ctrl_r[BIT_TX_LOOP_DOWN_SELECT];
    // underrun sends zeros; enforcer, when on, covers them
    wire pay_bit = (left_r == 4'h0) ? (fifo_valid & fifo_data[7]) : sh_r[7];
    wire [2:0] lc_len = loop_up ? LOOP_UP_LEN : LOOP_DOWN_LEN;
    wire up_bit = LOOP_UP_CODE[3'(LOOP_UP_LEN - 3'h1 - lc_idx_r)];
    wire dn_bit = LOOP_DOWN_CODE[2'(LOOP_DOWN_LEN - 3'h1 - lc_idx_r)];
    wire data_bit = loop_up ? up_bit : (loop_dn ? dn_bit : pay_bit); // R1 R3
    // greedy: one forced mark per bit, enough for any stream it has shaped itself
    wire enf_bit = data_bit | (tx_ctrl_r[BIT_DENSITY_ENFORCER_ENABLE] & tx_zero_bad); // R8
    wire out_bit = tx_fslot ? tx_fbit : enf_bit; // R2
    assign tx_line = tx_line_r;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sh_r <= 8'h00;
            left_r <= 4'h0;
            lc_idx_r <= 3'h0;
            tx_line_r <= 1'b0;
        end
        else
        begin
            // loop index restarts whenever neither select is set, without waiting for a tick, so a code started from idle opens on its first bit
            if (tx_bit_tick)
                tx_line_r <= out_bit;
            if (pay_take)
            begin
                sh_r <= {fifo_data[6:0], 1'b0};
                left_r <= fifo_valid ? 4'h7 : 4'h0;
            end
            else if (pay_tick)
            begin
                sh_r <= {sh_r[6:0], 1'b0};
                left_r <= left_r - 4'h1;
            end
            if (!(loop_up | loop_dn))
                lc_idx_r <= 3'h0;
            else if (pay_tick)
                lc_idx_r <= (lc_idx_r + 3'h1 >= lc_len) ? 3'h0 : lc_idx_r + 3'h1;
        end
    end

    tfs_dens_mon u_tx_mon (
        .core_clk(core_clk),
        .resetn(resetn),
        .bit_tick(tx_bit_tick),
        .bit_in(out_bit),
        .viol_r(tx_viol),
        .zero_would_viol(tx_zero_bad)
    );

    tfs_dens_mon u_rx_mon (
        .core_clk(core_clk),
        .resetn(resetn),
        .bit_tick(rx_bit_tick),
        .bit_in(rx_line),
        .viol_r(rx_viol),
        .zero_would_viol()
    );
endmodule

//--- tfs_host.sv
`timescale 1ns/100ps
module tfs_host
    import tfs_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    tfs_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire tfs_op_e cmd_op,
    input wire logic [1:0] cmd_fsel,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic b8zs_mode,
    input wire logic sysclk_stable,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic init_done,
    output logic irq_active
);
    typedef enum logic [2:0] {H_INIT, H_ESR, H_IDLE, H_RD, H_RWAIT, H_WB} tfs_hstate_e;
    tfs_hstate_e state_r;
    logic [4:0] init_cnt_r;
    logic poll_r;
    logic [7:0] mask_r;
    logic [1:0] fsel_r;
    logic [3:0] addr_r;
    logic wr_r;
    logic rd_r;
    logic [7:0] wdata_r;

    assign bus.reg_wr = wr_r;
    assign bus.reg_rd = rd_r;
    assign bus.reg_fsel = fsel_r;
    assign bus.reg_addr = addr_r;
    assign bus.reg_wdata = wdata_r;
    assign irq_active = !bus.int_n;
    assign cmd_ready = state_r == H_IDLE;
    assign init_done = state_r != H_INIT && state_r != H_ESR;

    // control writes: never both loop selects, no enforcer under B8ZS
    wire is_ctrl = cmd_addr == IDX_TX_CTRL;
    wire both_loops = cmd_data[BIT_TX_LOOP_UP_SELECT] & cmd_data[BIT_TX_LOOP_DOWN_SELECT];
    wire [7:0] ctrl_fix = cmd_data & ~(8'(both_loops) << BIT_TX_LOOP_DOWN_SELECT) // R4
                        & ~(8'(b8zs_mode) << BIT_DENSITY_ENFORCER_ENABLE); // R9
    wire [7:0] wr_val = is_ctrl ? ctrl_fix : cmd_data;
    wire [3:0] init_addr = IDX_IRQ_MASK_FIRST + {1'b0, init_cnt_r[2:0]};
    wire accept = cmd_valid & cmd_ready;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= H_INIT;
            init_cnt_r <= 5'h00;
            poll_r <= 1'b0;
            mask_r <= 8'h00;
            fsel_r <= 2'h0;
            addr_r <= 4'h0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            wdata_r <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
        end
        else
        begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            rsp_valid <= 1'b0;
            unique case (state_r)
                H_INIT:
                begin
                    // zero registers 4 to 8 (irq masks, tx control, indicator, elastic store) of every framer; status registers are not written
                    fsel_r <= init_cnt_r[4:3];
                    addr_r <= init_addr;
                    wdata_r <= 8'h00;
                    wr_r <= init_addr <= IDX_ES_CTRL; // R10
                    init_cnt_r <= init_cnt_r + 5'h01;
                    if (init_cnt_r == 5'h1f)
                    begin
                        init_cnt_r <= 5'h00;
                        state_r <= H_ESR;
                    end
                end
                H_ESR:
                begin
                    if (sysclk_stable) // R11
                    begin
                        fsel_r <= init_cnt_r[1:0];
                        addr_r <= IDX_ES_CTRL;
                        wdata_r <= 8'h01 << BIT_ELASTIC_STORE_RESET;
                        wr_r <= 1'b1;
                        init_cnt_r <= init_cnt_r + 5'h01;
                        if (init_cnt_r == 5'(NUM_FRAMERS - 1))
                            state_r <= H_IDLE;
                    end
                end
                H_IDLE:
                begin
                    if (accept)
                    begin
                        fsel_r <= cmd_fsel;
                        addr_r <= cmd_addr;
                        wdata_r <= wr_val;
                        mask_r <= cmd_data;
                        poll_r <= cmd_op == OP_POLL;
                        wr_r <= cmd_op != OP_READ; // R17
                        rd_r <= cmd_op == OP_READ;
                        rsp_valid <= cmd_op == OP_WRITE;
                        if (cmd_op == OP_POLL)
                            state_r <= H_RD;
                        else if (cmd_op == OP_READ)
                            state_r <= H_RWAIT;
                    end
                end
                H_RD:
                begin
                    rd_r <= 1'b1; // R17
                    state_r <= H_RWAIT;
                end
                H_RWAIT:
                begin
                    if (bus.reg_rack)
                    begin
                        rsp_data <= poll_r ? (bus.reg_rdata & mask_r) : bus.reg_rdata;
                        if (poll_r)
                            state_r <= H_WB;
                        else
                        begin
                            rsp_valid <= 1'b1;
                            state_r <= H_IDLE;
                        end
                    end
                end
                H_WB:
                begin
                    wr_r <= 1'b1; // R17
                    wdata_r <= rsp_data;
                    rsp_valid <= 1'b1;
                    state_r <= H_IDLE;
                end
            endcase
        end
    end
endmodule

//--- tfs_if.sv
`timescale 1ns/100ps
interface tfs_if (
    input wire logic core_clk,
    input wire logic resetn
);
    logic reg_wr;
    logic reg_rd;
    logic [1:0] reg_fsel;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rack;
    logic int_o;
    logic int_oe;
    wire int_n;

    // open drain interrupt: pulled high unless driven
    assign int_n = int_oe ? int_o : 1'b1;

    modport dev (
        input reg_wr,
        input reg_rd,
        input reg_fsel,
        input reg_addr,
        input reg_wdata,
        output reg_rdata,
        output reg_rack,
        output int_o,
        output int_oe
    );

    modport host (
        output reg_wr,
        output reg_rd,
        output reg_fsel,
        output reg_addr,
        output reg_wdata,
        input reg_rdata,
        input reg_rack,
        input int_n
    );
endinterface

//--- tfs_pkg.sv
package tfs_pkg;
    // register indexes on the parallel control port
    localparam logic [3:0] IDX_STATUS_FIRST = 4'h0;
    localparam logic [3:0] IDX_STATUS_SECOND = 4'h1;
    localparam logic [3:0] IDX_RX_INFO_FIRST = 4'h2;
    localparam logic [3:0] IDX_RX_INFO_SECOND = 4'h3;
    localparam logic [3:0] IDX_IRQ_MASK_FIRST = 4'h4;
    localparam logic [3:0] IDX_IRQ_MASK_SECOND = 4'h5;
    localparam logic [3:0] IDX_TX_CTRL = 4'h6;
    localparam logic [3:0] IDX_FRAMER_IRQ_INDICATOR = 4'h7;
    localparam logic [3:0] IDX_ES_CTRL = 4'h8;
    localparam int NUM_STATUS = 4;
    localparam int NUM_FRAMERS = 4;

    // field positions
    localparam int BIT_TX_LOOP_UP_SELECT = 1;
    localparam int BIT_TX_LOOP_DOWN_SELECT = 2;
    localparam int BIT_DENSITY_ENFORCER_ENABLE = 3;
    localparam int BIT_TX_DENSITY_VIOLATION = 2;
    localparam int BIT_RX_DENSITY_VIOLATION = 1;
    localparam int BIT_ELASTIC_STORE_RESET = 0;

    // reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // loop codes, sent msb first and repeated
    localparam logic [4:0] LOOP_UP_CODE = 5'h01;
    localparam logic [2:0] LOOP_DOWN_CODE = 3'h1;
    localparam logic [2:0] LOOP_UP_LEN = 3'h5;
    localparam logic [2:0] LOOP_DOWN_LEN = 3'h3;

    // density limits
    localparam logic [4:0] MAX_ZERO_RUN = 5'h0f;
    localparam int DENS_N_MAX = 23;
    localparam logic [7:0] AGE_SAT = 8'hff;

    // payload buffering
    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 32;

    // host operations
    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_POLL} tfs_op_e;
endpackage
